// ===== design/enf_top.sv
// external request pin filter, trigger detection and wishbone register file
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`default_nettype none
module enf_top #(
	parameter int LF_DIV = enf_pkg::LF_DIV_CYC
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// pins and chip state
	input wire logic [enf_pkg::NCH-1:0] EXT_REQ_PIN,
	input wire logic [enf_pkg::NCH-1:0] PIN_OUT_EN,
	input wire logic [1:0] OP_MODE,
	// to interrupt latch
	output logic [enf_pkg::NCH-1:0] EXT_REQ,
	output logic IRQ
);
	import enf_pkg::*;

	logic [1:0] rst_sync_q;
	logic rst_n;

	////////////////////////////////////////////////////////////////////////
	// reset release
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// sampling dividers
	logic [15:0] lf_cnt_q, lf_cnt_d;
	logic [1:0] slow_cnt_q, slow_cnt_d;
	logic slow_tick_q, slow_tick_d;
	logic [3:0] gear_cnt_q, gear_cnt_d;
	enf_mode_t mode;

	assign mode = enf_mode_t'(OP_MODE);

	always_comb begin
		lf_cnt_d = lf_cnt_q + 16'h0001;
		slow_cnt_d = slow_cnt_q;
		slow_tick_d = 1'b0;
		gear_cnt_d = gear_cnt_q + 4'h1;
		if (lf_cnt_q == 16'(LF_DIV - 1)) begin
			lf_cnt_d = 16'h0000;
			slow_cnt_d = slow_cnt_q + 2'h1;
			slow_tick_d = (slow_cnt_q == SLOW_DIV_LAST);
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			lf_cnt_q <= 16'h0000;
			slow_cnt_q <= 2'h0;
			slow_tick_q <= 1'b0;
			gear_cnt_q <= 4'h0;
		end else begin
			lf_cnt_q <= lf_cnt_d;
			slow_cnt_q <= slow_cnt_d;
			slow_tick_q <= slow_tick_d;
			gear_cnt_q <= gear_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [NSEL-1:0][3:0] ctrl_q, ctrl_d;
	logic [NSEL-1:0] snap_q, snap_d;
	logic [NCH-1:0] gate_q, gate_d;
	logic [NCH-1:0] status_q, status_d;
	logic [NCH-1:0] irq_en_q, irq_en_d;
	logic [NCH-1:0] req_q, req_d;
	logic [NCH-1:0] prev_q;
	logic [NCH-1:0] flt;
	logic irq_q;
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;

	////////////////////////////////////////////////////////////////////////
	// per-channel filter and trigger
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic pin_eff;
		logic active;
		logic fast_en;
		logic samp_en;
		logic [1:0] need;
		logic rise;
		logic fall;
		logic hit;

		assign pin_eff = EXT_REQ_PIN[i] & ~PIN_OUT_EN[i];
		assign active = gate_q[i] & (mode != ENF_MODE_DEEP);

		always_comb begin
			fast_en = 1'b1;
			need = NEED_TWO;
			if (i != CH_FIVE) begin
				need = NEED_FAST;
				case (enf_ivl_t'(ctrl_q[i % NSEL][IVL_LSB +: 2]))
					ENF_IVL_DIV1: fast_en = 1'b1;
					ENF_IVL_DIV4: fast_en = (gear_cnt_q[1:0] == 2'h0);
					ENF_IVL_DIV8: fast_en = (gear_cnt_q[2:0] == 3'h0);
					ENF_IVL_DIV16: fast_en = (gear_cnt_q == 4'h0);
					default: fast_en = 1'b1;
				endcase
			end
			if (mode == ENF_MODE_SLOW) begin
				need = NEED_TWO;
			end
		end

		// channel five in fast mode samples every clock and needs two
		assign samp_en = active & ((mode == ENF_MODE_SLOW) ? slow_tick_q : fast_en);

		enf_filt u_filt (
			.clk(REF_CLK),
			.rst_n(rst_n),
			.clr(~gate_q[i]),
			.en(samp_en),
			.need(need),
			.pin(pin_eff),
			.level(flt[i])
		);

		assign rise = flt[i] & ~prev_q[i];
		assign fall = ~flt[i] & prev_q[i];

		always_comb begin
			hit = 1'b0;
			if (i == CH_FIVE) begin
				hit = fall;
			end else begin
				case (enf_trig_t'(ctrl_q[i % NSEL][TRIG_LSB +: 2]))
					ENF_TRIG_RISE: hit = rise;
					ENF_TRIG_FALL: hit = fall;
					ENF_TRIG_BOTH: hit = rise | fall;
					// reserved on channels one to three
					ENF_TRIG_HIGH: hit = (i == CH_FOUR) & flt[i];
					default: hit = 1'b0;
				endcase
			end
		end

		assign req_d[i] = active & hit;
	end

	////////////////////////////////////////////////////////////////////////
	// request pipeline, snapshot, interrupt status
	always_comb begin
		for (int k = 0; k < NSEL; k++) begin
			snap_d[k] = req_d[k] ? flt[k] : snap_q[k];
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
			req_q <= '0;
			snap_q <= '0;
			irq_q <= 1'b0;
		end else begin
			prev_q <= flt;
			req_q <= req_d;
			snap_q <= snap_d;
			irq_q <= |(status_q & irq_en_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after the request, dropped the next
	logic bus_req;
	logic bus_wr;
	logic [NCH-1:0] clr_mask;

	assign bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
	assign bus_wr = bus_req & WB_WE_I & WB_SEL_I[0];

	always_comb begin
		ack_d = bus_req;
		dat_d = 32'h0000_0000;
		ctrl_d = ctrl_q;
		gate_d = gate_q;
		irq_en_d = irq_en_q;
		clr_mask = '0;
		if (bus_wr) begin
			for (int k = 0; k < NSEL; k++) begin
				if (WB_ADR_I == OFS_CTRL0 + 8'(4 * k)) begin
					ctrl_d[k] = WB_DAT_I[3:0];
				end
			end
			case (WB_ADR_I)
				OFS_CLK_GATE: gate_d = WB_DAT_I[NCH-1:0];
				OFS_CLEAR: clr_mask = WB_DAT_I[NCH-1:0];
				OFS_IRQ_EN: irq_en_d = WB_DAT_I[NCH-1:0];
				default: ;
			endcase
		end
		if (bus_req && !WB_WE_I) begin
			for (int k = 0; k < NSEL; k++) begin
				if (WB_ADR_I == OFS_CTRL0 + 8'(4 * k)) begin
					dat_d[SNAP_BIT:0] = {snap_q[k], ctrl_q[k]};
				end
			end
			case (WB_ADR_I)
				OFS_CLK_GATE: dat_d[NCH-1:0] = gate_q;
				OFS_STATUS: dat_d[NCH-1:0] = status_q;
				OFS_IRQ_EN: dat_d[NCH-1:0] = irq_en_q;
				default: ;
			endcase
		end
		// a new event wins over a clear in the same cycle
		status_d = (status_q & ~clr_mask) | req_q;
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			ctrl_q <= {NSEL{CTRL_RST}};
			gate_q <= GATE_RST;
			irq_en_q <= IRQ_EN_RST;
			status_q <= '0;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
			ctrl_q <= ctrl_d;
			gate_q <= gate_d;
			irq_en_q <= irq_en_d;
			status_q <= status_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;
	assign EXT_REQ = req_q;
	assign IRQ = irq_q;
endmodule
`default_nettype wire

// ===== design/enf_pkg.sv
// constants and types for the external request noise filter and edge detector
`default_nettype none
package enf_pkg;
	localparam int NCH = 5;
	localparam int NSEL = 4;
	localparam int CH_FIVE = 4;
	localparam int CH_FOUR = 3;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CLK_GATE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CLEAR = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN = 8'h1C;

	// control register fields
	localparam int TRIG_LSB = 0;
	localparam int IVL_LSB = 2;
	localparam int SNAP_BIT = 4;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [NCH-1:0] GATE_RST = 5'h00;
	localparam logic [NCH-1:0] IRQ_EN_RST = 5'h00;

	// timing
	localparam longint REF_CLK_HZ = 100_000_000;
	localparam longint LF_CLK_HZ = 32_768;
	localparam int LF_DIV_CYC = int'(REF_CLK_HZ / LF_CLK_HZ);
	localparam logic [1:0] SLOW_DIV_LAST = 2'h3;
	localparam logic [1:0] NEED_FAST = 2'h3;
	localparam logic [1:0] NEED_TWO = 2'h2;

	typedef enum logic [1:0] {
		ENF_MODE_FAST = 2'b00,
		ENF_MODE_SLOW = 2'b01,
		ENF_MODE_DEEP = 2'b10
	} enf_mode_t;

	typedef enum logic [1:0] {
		ENF_TRIG_RISE = 2'b00,
		ENF_TRIG_FALL = 2'b01,
		ENF_TRIG_BOTH = 2'b10,
		ENF_TRIG_HIGH = 2'b11
	} enf_trig_t;

	typedef enum logic [1:0] {
		ENF_IVL_DIV1 = 2'b00,
		ENF_IVL_DIV4 = 2'b01,
		ENF_IVL_DIV8 = 2'b10,
		ENF_IVL_DIV16 = 2'b11
	} enf_ivl_t;
endpackage
`default_nettype wire

// ===== design/enf_filt.sv
// consecutive-sample noise filter for one request pin
`default_nettype none
module enf_filt (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic clr,
	input wire logic en,
	input wire logic [1:0] need,
	// data
	input wire logic pin,
	output logic level
);
	logic last_q, last_d;
	logic [1:0] run_q, run_d;
	logic level_q, level_d;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		last_d = last_q;
		run_d = run_q;
		level_d = level_q;
		if (clr) begin
			last_d = 1'b0;
			run_d = 2'h0;
			level_d = 1'b0;
		end else if (en) begin
			last_d = pin;
			// saturating run length of equal samples
			if (pin != last_q || run_q == 2'h0) begin
				run_d = 2'h1;
			end else if (run_q != 2'h3) begin
				run_d = run_q + 2'h1;
			end
			if (run_d >= need) begin
				level_d = pin;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_q <= 1'b0;
			run_q <= 2'h0;
			level_q <= 1'b0;
		end else begin
			last_q <= last_d;
			run_q <= run_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule
`default_nettype wire

// ===== tb/enf_pin_src.sv
// pin source model: off-chip request drivers
`default_nettype none
module enf_pin_src (
	// clock
	input wire logic clk,
	// wanted levels
	input wire logic [4:0] want,
	// pins
	output logic [4:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// drivers switch just after the edge, never mid-cycle
	always_ff @(posedge clk) begin
		pin <= want;
	end
endmodule
`default_nettype wire

// ===== tb/enf_top_properties.sv
// concurrent checks on the request filter top ports
`default_nettype none
module enf_top_properties #(
	parameter int LF_DIV = 4
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// pins and requests
	input wire logic [4:0] EXT_REQ_PIN,
	input wire logic [4:0] PIN_OUT_EN,
	input wire logic [1:0] OP_MODE,
	input wire logic [4:0] EXT_REQ,
	input wire logic IRQ
);
	logic five_lo;
	assign five_lo = !EXT_REQ_PIN[4] || PIN_OUT_EN[4];
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	sequence s_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_quiet;
		EXT_REQ == 5'h00 && !IRQ && !WB_ACK_O;
	endsequence
	property p_ack;
		s_req |=> WB_ACK_O ##1 !WB_ACK_O;
	endproperty
	property p_dat;
		!WB_ACK_O |-> WB_DAT_O == 32'h0;
	endproperty
	property p_irq_rise;
		$rose(IRQ) |-> $past(EXT_REQ, 2) != 5'h00 || $past(WB_ACK_O);
	endproperty
	property p_irq_fall;
		$fell(IRQ) |-> $past(WB_ACK_O) && $past(WB_WE_I);
	endproperty
	property p_deep;
		(OP_MODE == 2'h2) [*3] |-> EXT_REQ == 5'h00;
	endproperty
	property p_five;
		EXT_REQ[4] |-> $past(five_lo, 2) && $past(five_lo, 3);
	endproperty
	property p_edge;
		EXT_REQ[0] |=> !EXT_REQ[0];
	endproperty
	property p_rst;
		$rose(RST_N) |-> s_quiet ##1 s_quiet;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing or too long");
	a_dat: assert property (p_dat) else $error("read data outside answer");
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
	a_deep: assert property (p_deep) else $error("request in deep mode");
	a_five: assert property (p_five) else $error("ch five request without low");
	a_edge: assert property (p_edge) else $error("edge request not a pulse");
	a_rst: assert property (p_rst) else $error("outputs busy after reset");
endmodule
bind enf_top enf_top_properties #(.LF_DIV(LF_DIV)) u_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .EXT_REQ_PIN(EXT_REQ_PIN), .PIN_OUT_EN(PIN_OUT_EN),
	.OP_MODE(OP_MODE), .EXT_REQ(EXT_REQ), .IRQ(IRQ));
`default_nettype wire

// ===== tb/enf_top_tb.sv
// self-checking bench for the request filter top
`default_nettype none
module enf_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import enf_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dati = 32'h0;
	logic [4:0] want = 5'h10;
	logic [4:0] oen = 5'h00;
	logic [1:0] mode = 2'h0;
	logic [4:0] prev = 5'h00;
	logic ack, irq;
	logic [31:0] dato;
	logic [4:0] pin, req;
	logic [31:0] rd_q[$];
	logic [31:0] ev_q[$];
	int err_count = 0;
	int samples_checked = 0;
	int t, k, iv;
	enf_pin_src u_src (.clk(clk), .want(want), .pin(pin));
	enf_top #(.LF_DIV(4)) u_dut (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cs), .WB_STB_I(cs),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dati), .WB_DAT_O(dato),
		.WB_ACK_O(ack), .EXT_REQ_PIN(pin), .PIN_OUT_EN(oen), .OP_MODE(mode),
		.EXT_REQ(req), .IRQ(irq));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (e !== g) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// a read pushes its expected data, the watcher compares at ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		if (!w) rd_q.push_back(d);
		@(posedge clk);
		cs <= 1'b1;
		we <= w;
		adr <= a;
		dati <= d;
		// ack is read at the edge itself, so this sees its pre-edge value
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		cs <= 1'b0;
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk);
		#1;
		chk("irq", 32'(e), {31'h0, irq});
	endtask
	task automatic stop_test;
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			chk("rd_data", rd_q.size() ? rd_q.pop_front() : 32'hDEAD, dato);
		end
		if (req !== prev && req !== 5'h00) begin
			chk("ext_req", ev_q.size() ? ev_q.pop_front() : 32'h0, {27'h0, req});
		end
		prev <= req;
	end
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		err_count++;
		stop_test();
	end
	initial begin
		void'($urandom(32'h7BB4));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1'b0, OFS_CLK_GATE, 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		bus(1'b1, OFS_CLK_GATE, 32'h1F);
		bus(1'b1, OFS_IRQ_EN, 32'h1F);
		for (k = 0; k < 4; k++) begin
			for (t = 0; t < 4; t++) begin
				iv = $urandom % 4;
				bus(1'b1, 8'(4 * k), 32'(t + 4 * iv));
				if (t != 1 && (t < 3 || k == 3)) ev_q.push_back(32'(1 << k));
				want[k] <= 1'b1;
				repeat (80) @(posedge clk);
				if (t == 1 || t == 2) ev_q.push_back(32'(1 << k));
				want[k] <= 1'b0;
				repeat (80) @(posedge clk);
				bus(1'b0, 8'(4 * k), 32'(t + 4 * iv + 16 * (t == 0 || t == 3 && k == 3)));
			end
		end
		// two equal samples only: rejected
		bus(1'b1, OFS_CTRL0, 32'h0);
		want[0] <= 1'b1;
		repeat (2) @(posedge clk);
		want[0] <= 1'b0;
		want[4] <= 1'b0;
		@(posedge clk);
		want[4] <= 1'b1;
		repeat (10) @(posedge clk);
		ev_q.push_back(32'h10);
		want[4] <= 1'b0;
		repeat (2) @(posedge clk);
		want[4] <= 1'b1;
		repeat (10) @(posedge clk);
		bus(1'b1, OFS_IRQ_EN, 32'h0);
		mode <= 2'h2;
		want[4] <= 1'b0;
		repeat (20) @(posedge clk);
		want[4] <= 1'b1;
		repeat (5) @(posedge clk);
		mode <= 2'h1;
		// twelve low-frequency periods of four clocks each
		repeat (12 * 4) @(posedge clk);
		bus(1'b1, OFS_CLEAR, 32'h1F);
		ev_q.push_back(32'h1);
		want[0] <= 1'b1;
		repeat (60) @(posedge clk);
		want[0] <= 1'b0;
		repeat (60) @(posedge clk);
		mode <= 2'h0;
		// two clocks plus three sampling intervals, longest interval assumed
		repeat (2 + 3 * 16) @(posedge clk);
		bus(1'b1, OFS_CLEAR, 32'h1F);
		bus(1'b1, OFS_CTRL0 + 8'h04, 32'h1);
		want[1] <= 1'b1;
		repeat (20) @(posedge clk);
		// interrupt enable is already low here
		ev_q.push_back(32'h2);
		oen[1] <= 1'b1;
		repeat (20) @(posedge clk);
		oen[1] <= 1'b0;
		repeat (20) @(posedge clk);
		bus(1'b0, OFS_STATUS, 32'h2);
		bus(1'b1, OFS_IRQ_EN, 32'h0);
		irq_is(1'b0);
		bus(1'b1, OFS_IRQ_EN, 32'h1F);
		irq_is(1'b1);
		bus(1'b1, OFS_CLEAR, 32'h1F);
		irq_is(1'b0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("events_left", 32'h0, 32'(ev_q.size()));
		stop_test();
	end
endmodule
`default_nettype wire
